// *** rtl/afe_ctl_pkg.sv ***
// Package: register map, field layout, reset values and timing for the front-end control
package afe_ctl_pkg;
  // Device register addresses
  localparam logic [7:0] MUX_CTL_ADDR = 8'h02;
  localparam logic [7:0] AMP_SETTING_ADDR = 8'h03;
  localparam logic [7:0] VREF_CONTROL_ADDR = 8'h05;
  // Field positions
  localparam int POS_SEL_LSB = 4;
  localparam int NEG_SEL_LSB = 0;
  localparam int AMP_POWER_LSB = 3;
  localparam int GAIN_LSB = 0;
  localparam int VREF_SOURCE_LSB = 2;
  localparam int VREF_POWER_LSB = 0;
  // Reset values
  localparam logic [7:0] MUX_CTL_RST = 8'h01;
  localparam logic [7:0] AMP_SETTING_RST = 8'h00;
  localparam logic [7:0] VREF_CONTROL_RST = 8'h00;
  // Codes
  localparam logic [1:0] AMP_BYPASS = 2'h0;
  localparam logic [1:0] AMP_ENABLED = 2'h1;
  localparam logic [1:0] VREF_SRC_EXT0 = 2'h0;
  localparam logic [1:0] VREF_SRC_EXT1 = 2'h1;
  localparam logic [1:0] VREF_SRC_INT = 2'h2;
  localparam logic [1:0] VREF_PWR_OFF = 2'h0;
  localparam logic [1:0] VREF_PWR_ON_PD = 2'h1;
  localparam logic [1:0] VREF_PWR_ALWAYS = 2'h2;
  localparam logic [3:0] SEL_MID_SUPPLY = 4'hc;
  localparam logic [3:0] SEL_ASUPPLY_QTR = 4'hd;
  localparam logic [3:0] SEL_DSUPPLY_QTR = 4'he;
  localparam logic [2:0] GAIN_CODE_32 = 3'h5;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BREAK_CLK_PERIODS = 2;
  localparam int BREAK_CYCLES = BREAK_CLK_PERIODS;
  localparam real VREF_SETTLE_MS = 4.5;
  localparam int VREF_SETTLE_CYCLES = int'(VREF_SETTLE_MS * 1.0e9 / CLK_PERIOD_PS);
  // Control port addresses of the host controller
  localparam logic [3:0] HC_MUX_ADDR = 4'h0;
  localparam logic [3:0] HC_AMP_ADDR = 4'h1;
  localparam logic [3:0] HC_VREF_ADDR = 4'h2;
  localparam logic [3:0] HC_STATUS_ADDR = 4'h3;
endpackage

// *** rtl/afe_cfg_if.sv ***
// Interface: configuration write path between host controller and front-end device
`timescale 1ns/1ps
`default_nettype none
interface afe_cfg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  modport host (output wr_en, output wr_addr, output wr_data);
  modport dev (input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// *** rtl/afe_input_ref_control.sv ***
// Device end: front-end register bank, input switching and reference decode
//
// Function
// - Channel change: mid-supply two clocks, then connect
// - Monitor code shorts inputs at mid-supply
// - Monitor codes for quarter supply measurements
// - Three-bit gain field at offset 03h
// - Enable 00 bypasses, 01 enables amplifier
// - Host never writes enable codes 10, 11
// - Gains 64, 128: analog 32 plus digital
// - Host bypasses only at unity gain
// - Reference select at 05h, default first external
// - Select code 10 routes internal reference
// - Power 10 always on, 01 off in power-down
// - Reference powered down after reset
// - Host powers reference when current sources used; host here only forwards the power code software writes
// - Host waits reference settling before converting
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module afe_input_ref_control
  import afe_ctl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration port
  afe_cfg_if.dev cfg,
  // Power-down mode from the converter
  input wire logic power_down,
  // Analog switch controls
  output logic [3:0] pos_input_sel,
  output logic [3:0] neg_input_sel,
  output logic inputs_to_mid,
  output logic monitor_short,
  output logic monitor_asupply,
  output logic monitor_dsupply,
  // Amplifier controls
  output logic input_amp_on,
  output logic [7:0] gain_total,
  output logic [7:0] gain_analog,
  output logic [2:0] digital_shift,
  // Reference controls
  output logic [1:0] vref_source_sel,
  output logic vref_internal_route,
  output logic vref_internal_on,
  // Readback of stored registers
  output logic [7:0] mux_ctl_reg,
  output logic [7:0] amp_setting_reg,
  output logic [7:0] vref_control_reg
);
  // Break-before-make counter and write decode
  logic [1:0] break_cnt_reg;
  logic [7:0] mux_next;
  logic mux_change;

  // Live fields of the stored settings
  logic [2:0] gain_code;
  logic amp_en;
  logic [1:0] vref_pw;
  logic [1:0] vref_src;

  // Positive channel field of a mux word
  function automatic logic [3:0] pos_field(logic [7:0] mux_word);
    return mux_word[POS_SEL_LSB +: 4];
  endfunction

  // Negative channel field of a mux word
  function automatic logic [3:0] neg_field(logic [7:0] mux_word);
    return mux_word[NEG_SEL_LSB +: 4];
  endfunction

  // Gain as a power of two of its code
  function automatic logic [7:0] gain_of(logic [2:0] code);
    return 8'h01 << code;
  endfunction

  // Mux write decode, a rewrite of the same word is no change
  assign mux_next = cfg.wr_data;
  assign mux_change = cfg.wr_en && cfg.wr_addr == MUX_CTL_ADDR && mux_next != mux_ctl_reg;

  // Amplifier field taps
  assign gain_code = amp_setting_reg[GAIN_LSB +: 3];
  assign amp_en = amp_setting_reg[AMP_POWER_LSB +: 2] == AMP_ENABLED;

  // Reference field taps
  assign vref_pw = vref_control_reg[VREF_POWER_LSB +: 2];
  assign vref_src = vref_control_reg[VREF_SOURCE_LSB +: 2];

  // Mux register write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_ctl_reg <= MUX_CTL_RST;
    end else if (cfg.wr_en && cfg.wr_addr == MUX_CTL_ADDR) begin
      mux_ctl_reg <= cfg.wr_data;
    end
  end

  // Amplifier register write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_setting_reg <= AMP_SETTING_RST;
    end else if (cfg.wr_en && cfg.wr_addr == AMP_SETTING_ADDR) begin
      amp_setting_reg <= cfg.wr_data;
    end
  end

  // Reference register write, reset leaves first pair and power off
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vref_control_reg <= VREF_CONTROL_RST;
    end else if (cfg.wr_en && cfg.wr_addr == VREF_CONTROL_ADDR) begin
      vref_control_reg <= cfg.wr_data;
    end
  end

  // Break-before-make sequencing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      break_cnt_reg <= 2'h0;
      inputs_to_mid <= 1'b0;
      pos_input_sel <= MUX_CTL_RST[POS_SEL_LSB +: 4];
      neg_input_sel <= MUX_CTL_RST[NEG_SEL_LSB +: 4];
    end else if (mux_change) begin
      break_cnt_reg <= 2'(BREAK_CYCLES - 1);
      inputs_to_mid <= 1'b1;
    end else if (break_cnt_reg != 2'h0) begin
      break_cnt_reg <= break_cnt_reg - 2'h1;
    end else if (inputs_to_mid) begin
      inputs_to_mid <= 1'b0;
      pos_input_sel <= pos_field(mux_ctl_reg);
      neg_input_sel <= neg_field(mux_ctl_reg);
    end
  end

  // Monitor decode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_short <= 1'b0;
      monitor_asupply <= 1'b0;
      monitor_dsupply <= 1'b0;
    end else begin
      monitor_short <= pos_field(mux_ctl_reg) == SEL_MID_SUPPLY;
      monitor_asupply <= pos_field(mux_ctl_reg) == SEL_ASUPPLY_QTR;
      monitor_dsupply <= pos_field(mux_ctl_reg) == SEL_DSUPPLY_QTR;
    end
  end

  // Amplifier enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_amp_on <= 1'b0;
    end else begin
      input_amp_on <= amp_en;
    end
  end

  // Total gain seen by the results
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_total <= 8'h01;
    end else begin
      gain_total <= gain_of(gain_code);
    end
  end

  // Split of gain between amplifier and digital scaling
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_analog <= 8'h01;
      digital_shift <= 3'h0;
    end else if (!amp_en) begin
      gain_analog <= 8'h01;
      digital_shift <= 3'h0;
    end else if (gain_code > GAIN_CODE_32) begin
      gain_analog <= gain_of(GAIN_CODE_32);
      digital_shift <= gain_code - GAIN_CODE_32;
    end else begin
      gain_analog <= gain_of(gain_code);
      digital_shift <= 3'h0;
    end
  end

  // Reference source select
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vref_source_sel <= VREF_SRC_EXT0;
    end else begin
      vref_source_sel <= vref_src;
    end
  end

  // Internal reference routing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vref_internal_route <= 1'b0;
    end else begin
      vref_internal_route <= vref_src == VREF_SRC_INT;
    end
  end

  // Internal reference power, optionally off in power-down
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vref_internal_on <= 1'b0;
    end else begin
      vref_internal_on <= vref_pw == VREF_PWR_ALWAYS || (vref_pw == VREF_PWR_ON_PD && !power_down);
    end
  end

endmodule
`default_nettype wire

// *** rtl/afe_host_ctl.sv ***
// Host end: accepts software writes and forwards them to the device
`timescale 1ns/1ps
`default_nettype none
module afe_host_ctl
  import afe_ctl_pkg::*;
#(
  parameter int SETTLE_CYCLES = VREF_SETTLE_CYCLES
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Software port
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // Device side
  afe_cfg_if.host cfg
);
  logic [7:0] mux_reg;
  logic [7:0] amp_reg;
  logic [7:0] vref_reg;
  logic [23:0] settle_cnt_reg;
  logic [7:0] amp_next;

  // Reserved enable codes map to bypass; bypass forces unity gain
  always_comb begin
    amp_next = sw_wdata;
    if (sw_wdata[AMP_POWER_LSB + 1]) amp_next[AMP_POWER_LSB +: 2] = AMP_BYPASS;
    if (amp_next[AMP_POWER_LSB +: 2] == AMP_BYPASS) amp_next[GAIN_LSB +: 3] = 3'h0;
  end

  // Shadows and forwarding
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_reg <= MUX_CTL_RST;
      amp_reg <= AMP_SETTING_RST;
      vref_reg <= VREF_CONTROL_RST;
      cfg.wr_en <= 1'b0;
      cfg.wr_addr <= 8'h00;
      cfg.wr_data <= 8'h00;
    end else begin
      cfg.wr_en <= 1'b0;
      if (sw_wr && sw_addr == HC_MUX_ADDR) begin
        mux_reg <= sw_wdata;
        {cfg.wr_en, cfg.wr_addr, cfg.wr_data} <= {1'b1, MUX_CTL_ADDR, sw_wdata};
      end
      if (sw_wr && sw_addr == HC_AMP_ADDR) begin
        amp_reg <= amp_next;
        {cfg.wr_en, cfg.wr_addr, cfg.wr_data} <= {1'b1, AMP_SETTING_ADDR, amp_next};
      end
      if (sw_wr && sw_addr == HC_VREF_ADDR) begin
        vref_reg <= sw_wdata;
        {cfg.wr_en, cfg.wr_addr, cfg.wr_data} <= {1'b1, VREF_CONTROL_ADDR, sw_wdata};
      end
    end
  end

  // Reference settling timer, restarts when power field turns on
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_reg <= 24'h0;
    end else if (sw_wr && sw_addr == HC_VREF_ADDR &&
                 sw_wdata[VREF_POWER_LSB +: 2] != VREF_PWR_OFF &&
                 vref_reg[VREF_POWER_LSB +: 2] == VREF_PWR_OFF) begin
      settle_cnt_reg <= 24'(SETTLE_CYCLES);
    end else if (settle_cnt_reg != 24'h0) begin
      settle_cnt_reg <= settle_cnt_reg - 24'h1;
    end
  end

  // Read data, one cycle after strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_rdata <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        HC_MUX_ADDR: sw_rdata <= mux_reg;
        HC_AMP_ADDR: sw_rdata <= amp_reg;
        HC_VREF_ADDR: sw_rdata <= vref_reg;
        HC_STATUS_ADDR: sw_rdata <= {6'h00, vref_reg[VREF_POWER_LSB +: 2] != VREF_PWR_OFF,
                                     settle_cnt_reg == 24'h0};
        default: sw_rdata <= 8'h00;
      endcase
    end else begin
      sw_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** dv/afe_ctl_assertions.sv ***
// Checker: timing and decode relations of the front-end control
`timescale 1ns/1ps
`default_nettype none
module afe_ctl_assertions
  import afe_ctl_pkg::*;
(
  // Clock, reset and interface
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic power_down,
  // Device outputs
  input wire logic [3:0] pos_input_sel,
  input wire logic inputs_to_mid,
  input wire logic monitor_short,
  input wire logic input_amp_on,
  input wire logic [7:0] gain_total,
  input wire logic [7:0] gain_analog,
  input wire logic vref_internal_route,
  input wire logic vref_internal_on,
  input wire logic [7:0] mux_ctl_reg,
  input wire logic [7:0] amp_setting_reg,
  input wire logic [7:0] vref_control_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Switching, monitor and decode relations
  chk_break_two_cycles: assert property (wr_en && wr_addr == MUX_CTL_ADDR &&
    wr_data != mux_ctl_reg |=> inputs_to_mid [*2] ##1 !inputs_to_mid) else $error("bad break");
  chk_connect_after: assert property ($fell(inputs_to_mid) |->
    pos_input_sel == mux_ctl_reg[7:4]) else $error("select not applied after break");
  chk_short_code: assert property ($rose(monitor_short) |->
    mux_ctl_reg[7:4] == SEL_MID_SUPPLY) else $error("short without its code");
  chk_gain_power: assert property ($stable(amp_setting_reg) |->
    gain_total == (8'h01 << amp_setting_reg[2:0])) else $error("gain decode wrong");
  chk_analog_cap: assert property (input_amp_on && gain_total > 8'h20 |->
    gain_analog == 8'h20) else $error("analog gain not capped");
  chk_bypass_unity: assert property (!input_amp_on |-> gain_analog == 8'h01)
    else $error("bypass gain not unity");
  chk_amp_enable: assert property ($stable(amp_setting_reg) |->
    input_amp_on == (amp_setting_reg[4:3] == AMP_ENABLED)) else $error("enable decode wrong");
  chk_int_route: assert property ($stable(vref_control_reg) |->
    vref_internal_route == (vref_control_reg[3:2] == VREF_SRC_INT)) else $error("route wrong");
  chk_ref_power: assert property ($stable(vref_control_reg) && $stable(power_down) |->
    vref_internal_on == (vref_control_reg[1:0] == VREF_PWR_ALWAYS ||
    (vref_control_reg[1:0] == VREF_PWR_ON_PD && !power_down))) else $error("power wrong");
endmodule
`default_nettype wire

// *** dv/afe_input_ref_control_tb_top.sv ***
// Testbench: host and device ends joined, driven from the software port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module afe_input_ref_control_tb_top
  import afe_ctl_pkg::*;
;
  logic ref_clk = 0, reset_n = 1, sw_wr = 0, sw_rd = 0, power_down = 0;
  logic [3:0] sw_addr = 0, pos_input_sel, neg_input_sel;
  logic [7:0] sw_wdata = 0, sw_rdata, gain_total, gain_analog, mux_ctl_reg, amp_setting_reg;
  logic [7:0] vref_control_reg, rdv;
  logic [2:0] digital_shift;
  logic [1:0] vref_source_sel;
  logic inputs_to_mid, monitor_short, monitor_asupply, monitor_dsupply, input_amp_on;
  logic vref_internal_route, vref_internal_on;
  int fail_count = 0, num_checks = 0, cycles = 0;
  // Clock, joined ends and checker
  always #2.5 ref_clk = ~ref_clk;
  afe_cfg_if afe_cfg_if_i ();
  afe_host_ctl #(.SETTLE_CYCLES(20)) afe_host_ctl_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .cfg(afe_cfg_if_i));
  afe_input_ref_control afe_input_ref_control_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .cfg(afe_cfg_if_i), .power_down(power_down), .pos_input_sel(pos_input_sel),
    .neg_input_sel(neg_input_sel), .inputs_to_mid(inputs_to_mid), .monitor_short(monitor_short),
    .monitor_asupply(monitor_asupply), .monitor_dsupply(monitor_dsupply),
    .input_amp_on(input_amp_on), .gain_total(gain_total), .gain_analog(gain_analog),
    .digital_shift(digital_shift), .vref_source_sel(vref_source_sel),
    .vref_internal_route(vref_internal_route), .vref_internal_on(vref_internal_on),
    .mux_ctl_reg(mux_ctl_reg), .amp_setting_reg(amp_setting_reg),
    .vref_control_reg(vref_control_reg));
  afe_ctl_assertions afe_ctl_assertions_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .wr_en(afe_cfg_if_i.wr_en), .wr_addr(afe_cfg_if_i.wr_addr), .wr_data(afe_cfg_if_i.wr_data),
    .power_down(power_down), .pos_input_sel(pos_input_sel), .inputs_to_mid(inputs_to_mid),
    .monitor_short(monitor_short), .input_amp_on(input_amp_on), .gain_total(gain_total),
    .gain_analog(gain_analog), .vref_internal_route(vref_internal_route),
    .vref_internal_on(vref_internal_on), .mux_ctl_reg(mux_ctl_reg),
    .amp_setting_reg(amp_setting_reg), .vref_control_reg(vref_control_reg));
  // Verdict and end of run
  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Software port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // Channel change with break length counted
  task automatic mux_set(input logic [7:0] d, input int brk);
    int n;
    n = 0;
    @(posedge ref_clk);
    sw_addr <= HC_MUX_ADDR;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    repeat (8) begin
      @(posedge ref_clk);
      #1 n += (inputs_to_mid === 1'b1);
    end
    `CHK("break", brk, n)
    `CHK("sel", d, {pos_input_sel, neg_input_sel})
  endtask
  task automatic t_mux;
    logic [3:0] c;
    mux_set(8'h34, 2);
    mux_set(8'h34, 0);
    for (int i = 12; i < 15; i++) begin
      c = 4'(i);
      mux_set({c, 4'h1}, 2);
      `CHK("mon", {c == SEL_MID_SUPPLY, c == SEL_ASUPPLY_QTR, c == SEL_DSUPPLY_QTR}, {monitor_short, monitor_asupply, monitor_dsupply})
    end
  endtask
  // Every gain code, then bypass at unity
  task automatic t_gain;
    for (int i = 0; i < 8; i++) begin
      wr(HC_AMP_ADDR, {3'h0, AMP_ENABLED, 3'(i)});
      `CHK("amp_reg", {3'h0, AMP_ENABLED, 3'(i)}, amp_setting_reg)
      `CHK("gain", 8'h01 << i, gain_total)
      `CHK("analog", (i > 5) ? 8'h20 : 8'h01 << i, gain_analog)
      `CHK("shift", (i > 5) ? 3'(i - 5) : 3'h0, digital_shift)
      `CHK("amp_on", 1'b1, input_amp_on)
    end
    wr(HC_AMP_ADDR, {3'h0, AMP_BYPASS, 3'h0});
    `CHK("bypass", {1'b0, 8'h01}, {input_amp_on, gain_analog})
  endtask
  // Reserved enable code and bypass above unity are mapped by the host
  task automatic t_amp_guard;
    wr(HC_AMP_ADDR, {3'h0, AMP_ENABLED, 3'h3});
    wr(HC_AMP_ADDR, {3'h0, 2'h3, 3'h3});
    `CHK("amp_rsvd", {3'h0, AMP_BYPASS, 3'h0}, amp_setting_reg)
    wr(HC_AMP_ADDR, {3'h0, AMP_ENABLED, 3'h4});
    rd(HC_AMP_ADDR, rdv);
    `CHK("rd_amp", {3'h0, AMP_ENABLED, 3'h4}, rdv)
    wr(HC_AMP_ADDR, {3'h0, AMP_BYPASS, 3'h4});
    `CHK("amp_byp", {1'b0, 8'h01, 8'h01}, {input_amp_on, gain_analog, gain_total})
  endtask
  // Settling status after the reference power field is set to 01 while power_down is still high
  task automatic t_settle;
    wr(HC_VREF_ADDR, {4'h0, VREF_SRC_INT, VREF_PWR_OFF});
    wr(HC_VREF_ADDR, {4'h0, VREF_SRC_INT, VREF_PWR_ON_PD});
    rd(HC_STATUS_ADDR, rdv);
    `CHK("settling", {6'h00, 1'b1, 1'b0}, rdv)
    repeat (20) @(posedge ref_clk);
    rd(HC_STATUS_ADDR, rdv);
    `CHK("settled", {6'h00, 1'b1, 1'b1}, rdv)
  endtask
  // Reference source and power codes
  task automatic t_vref;
    for (int s = 0; s < 3; s++) begin
      wr(HC_VREF_ADDR, {4'h0, 2'(s), VREF_PWR_ALWAYS});
      `CHK("src", {2'(s), s == 2}, {vref_source_sel, vref_internal_route})
    end
    for (int p = 0; p < 3; p++) for (int d = 0; d < 2; d++) begin
      @(posedge ref_clk);
      power_down <= 1'(d);
      wr(HC_VREF_ADDR, {4'h0, VREF_SRC_INT, 2'(p)});
      `CHK("ref_on", (p == 2 || (p == 1 && d == 0)), vref_internal_on)
    end
    rd(HC_VREF_ADDR, rdv);
    `CHK("rd_vref", {4'h0, VREF_SRC_INT, VREF_PWR_ALWAYS}, rdv)
    rd(HC_MUX_ADDR, rdv);
    `CHK("rd_mux", {SEL_DSUPPLY_QTR, 4'h1}, rdv)
    rd(4'h7, rdv);
    `CHK("rd_unmapped", 8'h00, rdv)
  endtask
  // Timeout watch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 `CHK("rst_regs", {MUX_CTL_RST, AMP_SETTING_RST, VREF_CONTROL_RST}, {mux_ctl_reg, amp_setting_reg, vref_control_reg})
    `CHK("rst_src", VREF_SRC_EXT0, vref_source_sel)
    `CHK("rst_ref", {1'b0, 8'h01}, {vref_internal_on, gain_total})
    t_mux();
    t_gain();
    t_amp_guard();
    t_vref();
    t_settle();
    report_and_stop();
  end
endmodule
`default_nettype wire
